//--- logic/printer_mailbox_command_service.sv
// Purpose: polls a mailbox byte in target memory and serves print requests
// Assumes: memory answers reads with rd_valid, accepts on mem_ready
// Notes: printer bytes pass a two-entry buffer; a stall loses nothing
`include "printer_mailbox_params.svh"
`timescale 1ns/1ps
`default_nettype none
module printer_mailbox_command_service
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // configuration
  input wire logic [15:0] mailbox_byte_address,
  // target memory port
  output printer_mailbox_pkg::mem_req_s mem_req,
  output logic mem_valid,
  input wire logic mem_ready,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  // printer byte stream
  output printer_mailbox_pkg::print_byte_s prn,
  output logic prn_valid,
  input wire logic prn_ready,
  // session status
  output logic session_open,
  output logic printer_busy_to_others
);
  import printer_mailbox_pkg::*;

  typedef enum {
    s_wait, s_read_cmd, s_read_len, s_check, s_read_char, s_put_char,
    s_put_cr, s_put_lf, s_put_ff, s_answer, s_done
  } state_e;

  state_e state;
  logic [15:0] poll_count;
  logic [7:0] len;
  logic [7:0] idx;
  logic [7:0] result;
  logic [7:0] chr;
  logic read_issued;
  logic [1:0][7:0] buf_data;
  logic [1:0] buf_fill;

  // two-entry buffer toward the printer
  wire buf_full = buf_fill == 2'd2;
  wire push_ready = !buf_full;
  wire pop = prn_valid && prn_ready;
  logic push;
  logic [7:0] push_data;

  wire poll_tick = poll_count == 16'(`POLL_CYCLES - 1);
  wire mem_done = mem_valid && mem_ready;
  wire cmd_pending = rd_data[`PENDING_BIT];
  wire len_bad = len > `MAX_RECORD;
  wire len_odd = len[0] || (len == 8'h00);
  wire char_bad = rd_data > `MAX_CHAR;
  wire last_char = (idx + 8'h01) == len;

  always_comb
  begin
    push = 1'b0;
    push_data = 8'h00;
    unique case (state)
      s_put_char:
      begin
        push = 1'b1;
        push_data = chr;
      end
      s_put_cr:
      begin
        push = 1'b1;
        push_data = `CHAR_CR;
      end
      s_put_lf:
      begin
        push = 1'b1;
        push_data = `CHAR_LF;
      end
      s_put_ff:
      begin
        push = 1'b1;
        push_data = `CHAR_FF;
      end
      default:
      begin
        push = 1'b0;
        push_data = 8'h00;
      end
    endcase
  end
  wire push_do = push && push_ready;

  always_ff @(posedge clk)
  begin
    if (reset)
      poll_count <= 16'h0000;
    else if (state != s_wait || poll_tick)
      poll_count <= 16'h0000;
    else
      poll_count <= poll_count + 16'h0001;
  end

  // buffer storage; entry 0 is the head
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      buf_fill <= 2'd0;
      buf_data <= '0;
    end
    else
    begin
      if (pop)
        buf_data[0] <= buf_data[1];
      if (push_do)
        buf_data[(pop ? buf_fill - 2'd1 : buf_fill) == 2'd0 ? 0 : 1]
          <= push_data;
      buf_fill <= buf_fill + 2'(push_do) - 2'(pop);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prn_valid <= 1'b0;
      prn <= '0;
    end
    else
    begin
      prn_valid <= (buf_fill + 2'(push_do) - 2'(pop)) != 2'd0;
      prn.data <= (buf_fill == 2'd0 || (pop && buf_fill == 2'd1))
        ? push_data : (pop ? buf_data[1] : buf_data[0]);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= s_wait;
      mem_valid <= 1'b0;
      mem_req <= '0;
      len <= 8'h00;
      idx <= 8'h00;
      result <= 8'h00;
      chr <= 8'h00;
      read_issued <= 1'b0;
      session_open <= 1'b0;
      printer_busy_to_others <= 1'b0;
    end
    else
    begin
      printer_busy_to_others <= session_open;
      if (mem_done)
        mem_valid <= 1'b0;
      unique case (state)
        s_wait:
          if (poll_tick)
          begin
            mem_req <= '{write: 1'b0, addr: mailbox_byte_address,
              data: 8'h00};
            mem_valid <= 1'b1;
            state <= s_read_cmd;
          end
        s_read_cmd:
          if (rd_valid)
          begin
            if (!cmd_pending)
              state <= s_wait;
            else if (rd_data == `CMD_OPEN)
            begin
              result <= session_open ? `ERR_STATE : `RESULT_OK;
              session_open <= 1'b1;
              state <= s_answer;
            end
            else if (rd_data == `CMD_CLOSE)
            begin
              result <= session_open ? `RESULT_OK : `ERR_STATE;
              state <= session_open ? s_put_ff : s_answer;
            end
            else if (rd_data == `CMD_WRITE && session_open)
            begin
              mem_req <= '{write: 1'b0,
                addr: mailbox_byte_address + 16'h0001, data: 8'h00};
              mem_valid <= 1'b1;
              state <= s_read_len;
            end
            else
            begin
              // unknown codes get a general error, write while closed 09
              result <= (rd_data == `CMD_WRITE) ? `ERR_STATE
                : `ERR_GENERAL;
              state <= s_answer;
            end
          end
        s_read_len:
          if (rd_valid)
          begin
            len <= rd_data;
            state <= s_check;
          end
        s_check:
        begin
          idx <= 8'h00;
          read_issued <= 1'b0;
          if (len_bad)
          begin
            result <= `ERR_LENGTH;
            state <= s_answer;
          end
          else if (len_odd)
          begin
            result <= `ERR_GENERAL;
            state <= s_answer;
          end
          else
            state <= s_read_char;
        end
        s_read_char:
          if (!read_issued)
          begin
            mem_req <= '{write: 1'b0, data: 8'h00,
              addr: mailbox_byte_address + 16'h0002 + {8'h00, idx}};
            mem_valid <= 1'b1;
            read_issued <= 1'b1;
          end
          else if (rd_valid)
          begin
            read_issued <= 1'b0;
            // refused bytes are skipped; the record answers a character error (02)
            if (char_bad)
              result <= `ERR_CHAR;
            chr <= rd_data;
            state <= char_bad ? (last_char ? s_put_cr : s_read_char)
              : s_put_char;
            idx <= idx + 8'h01;
          end
        s_put_char:
          if (push_ready)
            state <= (idx == len) ? s_put_cr : s_read_char;
        s_put_cr:
          if (push_ready)
            state <= s_put_lf;
        s_put_lf:
          if (push_ready)
            state <= s_answer;
        s_put_ff:
          if (push_ready)
          begin
            session_open <= 1'b0;
            state <= s_answer;
          end
        s_answer:
        begin
          mem_req <= '{write: 1'b1, addr: mailbox_byte_address,
            data: result};
          mem_valid <= 1'b1;
          state <= s_done;
        end
        s_done:
          if (!mem_valid)
          begin
            result <= `RESULT_OK;
            state <= s_wait;
          end
      endcase
    end
  end
endmodule : printer_mailbox_command_service
`default_nettype wire

//--- logic/printer_mailbox_params.svh
// Purpose: constants for the printer mailbox command service
// Assumes: byte-wide target memory port, one clock at 100 MHz
// Notes: times are in their own unit; cycle counts derive from them
`ifndef PRINTER_MAILBOX_PARAMS_SVH
`define PRINTER_MAILBOX_PARAMS_SVH
`define CMD_OPEN 8'h80
`define CMD_CLOSE 8'h81
`define CMD_WRITE 8'h82
`define RESULT_OK 8'h00
`define ERR_STATE 8'h09
`define ERR_LENGTH 8'h12
`define ERR_GENERAL 8'h01
`define ERR_CHAR 8'h02
`define MAX_RECORD 8'hF0
`define MAX_CHAR 8'hF0
`define CHAR_CR 8'h0D
`define CHAR_LF 8'h0A
`define CHAR_FF 8'h0C
`define PENDING_BIT 7
`define POLL_TIME_US 10
`define CLK_MHZ 100
`define POLL_CYCLES (`POLL_TIME_US * `CLK_MHZ)
`endif

//--- logic/printer_mailbox_pkg.sv
// Purpose: types for the printer mailbox command service
// Assumes: 16-bit addresses and byte data; widths are fixed here, not in the constants header
// Notes: memory requests and printer bytes travel as packed structs
package printer_mailbox_pkg;
  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [7:0] data;
  } mem_req_s;
  typedef struct packed {
    logic [7:0] data;
  } print_byte_s;
endpackage : printer_mailbox_pkg

//--- sim/printer_mailbox_props.sv
// Purpose: port checks for the command service
// Assumes: one clock, reset synchronous
// Notes: bound to every instance
`timescale 1ns/1ps
`default_nettype none
module printer_mailbox_props
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] mailbox_byte_address,
  input wire printer_mailbox_pkg::mem_req_s mem_req,
  input wire logic mem_valid,
  input wire logic mem_ready,
  input wire printer_mailbox_pkg::print_byte_s prn,
  input wire logic prn_valid,
  input wire logic prn_ready,
  input wire logic session_open,
  input wire logic printer_busy_to_others
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic wr_ok;
  assign wr_ok = mem_valid && mem_req.write && mem_req.data == 8'h00;
  // idle polls come 1000 cycles apart; a few cycles of slack for the answer
  logic [10:0] idle_count;
  always_ff @(posedge clk)
  begin
    if (reset || mem_valid)
      idle_count <= 11'h000;
    else if (idle_count != 11'h7FF)
      idle_count <= idle_count + 11'h001;
  end
  a_prn_hold: assert property (prn_valid && !prn_ready |=>
    prn_valid && $stable(prn)) else $error("printer byte lost");
  a_mem_hold: assert property (mem_valid && !mem_ready |=>
    mem_valid && $stable(mem_req)) else $error("request dropped");
  a_busy_follows: assert property (printer_busy_to_others ==
    $past(session_open)) else $error("busy not following session");
  a_poll_first: assert property (idle_count <= 11'h3ED)
    else $error("no poll");
  a_read_range: assert property (mem_valid && !mem_req.write |->
    16'(mem_req.addr - mailbox_byte_address) <= 16'd241)
    else $error("read outside record");
  a_result_box: assert property (mem_valid && mem_req.write |->
    mem_req.addr == mailbox_byte_address && !mem_req.data[7])
    else $error("bad result write");
  a_open_ok: assert property ($rose(session_open) |->
    (##[0:3] wr_ok) or $past(wr_ok)) else $error("open not answered");
  a_close_ok: assert property ($fell(session_open) |->
    (##[0:1000] wr_ok) or $past(wr_ok)) else $error("close not answered");
  c_open: cover property ($rose(session_open));
  c_print: cover property (prn_valid && prn_ready);
  c_refuse: cover property (mem_valid && mem_req.write && mem_req.data[3]);
endmodule : printer_mailbox_props
bind printer_mailbox_command_service printer_mailbox_props u_props (
  .clk(clk), .reset(reset), .mailbox_byte_address(mailbox_byte_address),
  .mem_req(mem_req), .mem_valid(mem_valid), .mem_ready(mem_ready),
  .prn(prn), .prn_valid(prn_valid), .prn_ready(prn_ready),
  .session_open(session_open),
  .printer_busy_to_others(printer_busy_to_others));
`default_nettype wire

//--- sim/target_memory_model.sv
// Purpose: target memory behind the command service
// Assumes: 256 bytes, low address byte selects
// Notes: ready stalls at random
`timescale 1ns/1ps
`default_nettype none
module target_memory_model
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // request side
  input wire printer_mailbox_pkg::mem_req_s mem_req,
  input wire logic mem_valid,
  output logic mem_ready,
  output logic [7:0] rd_data,
  output logic rd_valid
);
  import printer_mailbox_pkg::*;
  logic [7:0] mem [0:255];
  logic take;
  assign take = mem_valid && mem_ready;
  always @(posedge clk)
  begin
    mem_ready <= !reset && ($urandom_range(2, 0) != 0);
    rd_valid <= take && !mem_req.write;
    // idle data inverts so a stale read never passes
    rd_data <= (take && !mem_req.write) ? mem[mem_req.addr[7:0]] : ~rd_data;
    if (take && mem_req.write)
      mem[mem_req.addr[7:0]] <= mem_req.data;
  end
endmodule : target_memory_model
`default_nettype wire

//--- sim/tb_top.sv
// Purpose: self-checking bench for the command service
// Assumes: mailbox low byte 00, random high byte; model maps the low byte
// Notes: a poll takes 1000 cycles, so each command waits up to 3000
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import printer_mailbox_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic prn_ready = 1'b0;
  logic [15:0] mbox = 16'h1200;
  logic mem_ready, rd_valid, mem_valid, prn_valid, session_open, busy;
  logic [7:0] rd_data;
  mem_req_s mem_req;
  print_byte_s prn;
  logic [7:0] exp_b [$];
  logic [7:0] exp_r [$];
  int err_count = 0;
  int comparisons = 0;
  printer_mailbox_command_service u_dut (.clk(clk), .reset(reset),
    .mailbox_byte_address(mbox), .mem_req(mem_req),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .prn(prn), .prn_valid(prn_valid),
    .prn_ready(prn_ready), .session_open(session_open),
    .printer_busy_to_others(busy));
  target_memory_model u_mem (.clk(clk), .reset(reset), .mem_req(mem_req),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .rd_data(rd_data),
    .rd_valid(rd_valid));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic compare(input string name, input logic [7:0] e,
    input logic [7:0] g);
    comparisons++;
    // an unknown expectation means nothing was due, so it never matches
    if (g !== e || $isunknown(e))
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask : compare
  task automatic conclude();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude
  // an empty queue yields x, so an unexpected result never matches
  function automatic logic [7:0] take(ref logic [7:0] q [$]);
    return q.size() ? q.pop_front() : 8'hxx;
  endfunction : take
  always @(posedge clk)
  begin
    prn_ready <= $urandom_range(3, 0) != 0;
    if (prn_valid && prn_ready)
      compare("byte", take(exp_b), prn.data);
    if (mem_valid && mem_ready && mem_req.write)
      compare("result", take(exp_r), mem_req.data);
  end
  task automatic cmd(input logic [7:0] code, input logic [7:0] len,
    input logic [7:0] res, input logic [7:0] bad = 8'hFF);
    logic [7:0] b;
    logic fwd;
    int i;
    fwd = code == 8'h82 && (res == 8'h00 || res == 8'h02);
    @(negedge clk);
    u_mem.mem[1] = len;
    for (i = 0; i < len; i++)
    begin
      // every record is random text closed by a space pad, except that index bad holds F5
      b = (i == bad) ? 8'hF5 : (i == len - 1) ? 8'h20
        : 8'(8'h20 + $urandom_range(208, 0));
      u_mem.mem[2 + i] = b;
      if (fwd && i != bad)
        exp_b.push_back(b);
    end
    if (fwd)
    begin
      exp_b.push_back(8'h0D);
      exp_b.push_back(8'h0A);
    end
    if (code == 8'h81 && res == 8'h00)
      exp_b.push_back(8'h0C);
    exp_r.push_back(res);
    u_mem.mem[0] = code;
    for (i = 0; i < 3000 && u_mem.mem[0][7] !== 1'b0; i++)
      @(posedge clk);
    if (i == 3000)
    begin
      err_count++;
      conclude();
    end
  endtask : cmd
  initial
  begin
    void'($urandom(24));
    u_mem.mem[0] = 8'h00;
    repeat (20) @(posedge clk);
    mbox <= {8'($urandom_range(255, 1)), 8'h00};
    reset <= 1'b0;
    cmd(8'h82, 8'd2, 8'h09);
    cmd(8'h81, 8'd0, 8'h09);
    cmd(8'h80, 8'd0, 8'h00);
    compare("busy", 8'h01, {7'h00, busy});
    cmd(8'h80, 8'd0, 8'h09);
    cmd(8'h82, 8'd2, 8'h00);
    cmd(8'h82, 8'd240, 8'h00);
    cmd(8'h82, 8'd242, 8'h12);
    cmd(8'h82, 8'd3, 8'h01);
    cmd(8'h90, 8'd0, 8'h01);
    cmd(8'h82, 8'd6, 8'h02, 8'd3);
    cmd(8'h81, 8'd0, 8'h00);
    compare("session", 8'h00, {7'h00, session_open});
    repeat (200) @(posedge clk);
    compare("left", 8'h00, 8'(exp_b.size()));
    compare("results left", 8'h00, 8'(exp_r.size()));
    conclude();
  end
endmodule : tb_top
`default_nettype wire
